// [logic/mcb_pkg.sv]
// mcb_pkg: constants for the motor control configuration byte B block
// assumes a 32-bit AHB-Lite register bus and one 25 MHz clock
`default_nettype none
package mcb_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_CFG_B   = 8'h00;
  localparam logic [7:0] ADDR_BITOP   = 8'h04;
  localparam logic [7:0] ADDR_CTRL    = 8'h08;
  localparam logic [7:0] ADDR_PHASE   = 8'h0C;
  localparam logic [7:0] ADDR_ACTIVE  = 8'h10;
  localparam logic [7:0] ADDR_IRQ_ST  = 8'h14;
  localparam logic [7:0] ADDR_IRQ_CLR = 8'h18;
  localparam logic [7:0] ADDR_IRQ_EN  = 8'h1C;
  // configuration byte B fields
  localparam int BIT_EDGE_POL = 6;
  localparam int BIT_HW_DEMAG = 5;
  localparam int BIT_SIM_DEMAG = 4;
  localparam int BIT_OCV      = 3;
  localparam int BIT_OS2      = 2;
  localparam int BIT_OS1      = 1;
  localparam int BIT_OS0      = 0;
  localparam logic [7:0] CFG_B_RESET = 8'h00;
  // preloaded positions: 6,5,4,2,1,0
  localparam logic [7:0] PRELOAD_MASK = 8'h77;
  // bit operation register fields
  localparam int BITOP_VAL = 8;
  // control register fields
  localparam int CTRL_MOE   = 0;
  localparam int CTRL_DAC   = 1;
  localparam int CTRL_SR    = 2;
  localparam int CTRL_CMS   = 3;
  localparam int CTRL_PCN   = 4;
  localparam int CTRL_CURRENT_LIMIT_IRQ_ENABLE  = 5;
  localparam logic [5:0] CTRL_RESET = 6'h00;
  localparam logic [5:0] PHASE_RESET = 6'h00;
  // reset level of each motor output while outputs are disabled
  localparam logic [5:0] OUT_RESET_LEVEL = 6'h00;
  // outputs 0,2,4 are high channels, 1,3,5 low channels
  localparam logic [5:0] HIGH_CH_MASK = 6'h15;
  // interrupt status bits
  localparam int IRQ_CURRENT_LIMIT_IRQ_ENABLE  = 0;
  localparam int IRQ_HDM   = 1;
  localparam int IRQ_SDM   = 2;
  localparam int IRQ_ZC    = 3;
  localparam int IRQ_W     = 4;
  localparam logic [3:0] IRQ_RESET = 4'h0;
  // htrans encoding
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  typedef enum logic [1:0] {
    STEP_CD,
    STEP_DZ,
    STEP_ZC
  } mcb_step_e;
endpackage
`default_nettype wire

// [logic/mcb_top.sv]
// mcb_top: configuration byte B of the motor control block, behind AHB-Lite
// assumes commutation, demag and pwm inputs come from logic on hclk,
// comparator and current loop inputs come from pins
//
// Decided for this implementation: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - preloaded bits take effect at commutation, or phase write in direct access
// - all preloaded bits move to their active copies on one update edge
// - bit 6: zero crossing on falling edge (0) or rising edge (1)
// - bit 5 enables hardware demagnetization events
// - bit 4 enables simulated demagnetization events
// - bit 3 turns overcurrent protection in voltage mode on
// - limit irq disabled: no interrupt; pwm off while current loop flag set
// - limit irq on and flag set: interrupt; protection on clears output enable
// - output reset also with three pwm outputs, only in voltage mode
// - sensorless: bits 2,1,0 pick pwm side for C-D, D-Z, Z-C steps
// - sensor mode: bit 2 for C-Z, bit 0 for Z-C, bit 1 ignored
// - direct access: only bit 0 picks pwm side
// - single-bit operation on a non-preloaded bit clears all preloaded bits
// - output enable low: every motor output at its reset level
// - direct access: outputs follow phase state, gated by pwm
module mcb_top (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        comm_event,
  input  wire logic        demag_event,
  input  wire logic        hw_demag_in,
  input  wire logic        sim_demag_in,
  input  wire logic        pwm_in,
  input  wire logic [5:0]  run_pattern,
  input  wire logic        bemf_cmp_pin,
  input  wire logic        current_loop_pin,
  output logic      [5:0]  motor_outputs,
  output logic             pwm_on_low,
  output logic             zc_event,
  output logic             hw_demag_evt,
  output logic             sim_demag_evt,
  output logic             irq
);

  // register state
  logic [7:0]             cfg_pre_q;
  logic [7:0]             cfg_pre_d;
  logic [7:0]             cfg_act_q;
  logic [7:0]             cfg_act_d;
  logic [5:0]             ctrl_q;
  logic [5:0]             ctrl_d;
  logic [5:0]             phase_q;
  logic [5:0]             phase_d;
  logic [3:0]             irq_st_q;
  logic [3:0]             irq_st_d;
  logic [3:0]             irq_en_q;
  logic [3:0]             irq_en_d;
  mcb_pkg::mcb_step_e     step_q;
  mcb_pkg::mcb_step_e     step_d;

  // bus data phase
  logic                   wr_pend_q;
  logic [7:0]             wr_addr_q;
  logic [31:0]            hrdata_q;
  logic [31:0]            hrdata_d;

  // synchronisers
  logic                   cmp_s1_q;
  logic                   cmp_s2_q;
  logic                   cmp_s3_q;
  logic                   clf_s1_q;
  logic                   clf_s2_q;

  // registered outputs
  logic [5:0]             out_q;
  logic [5:0]             out_d;
  logic                   low_q;
  logic                   zc_q;
  logic                   hdm_q;
  logic                   sdm_q;
  logic                   irq_q;

  // address phase decode
  wire        addr_ok   = hsel & hready & (htrans == mcb_pkg::HTRANS_NONSEQ);
  wire        wr_start  = addr_ok & hwrite;
  wire        rd_start  = addr_ok & ~hwrite;
  wire [7:0]  ra        = haddr[7:0];

  // data phase write decode
  wire        wr_cfg    = wr_pend_q & (wr_addr_q == mcb_pkg::ADDR_CFG_B);
  wire        wr_bitop  = wr_pend_q & (wr_addr_q == mcb_pkg::ADDR_BITOP);
  wire        wr_ctrl   = wr_pend_q & (wr_addr_q == mcb_pkg::ADDR_CTRL);
  wire        wr_phase  = wr_pend_q & (wr_addr_q == mcb_pkg::ADDR_PHASE);
  wire        wr_clr    = wr_pend_q & (wr_addr_q == mcb_pkg::ADDR_IRQ_CLR);
  wire        wr_en     = wr_pend_q & (wr_addr_q == mcb_pkg::ADDR_IRQ_EN);

  // single-bit operation
  wire [2:0]  bit_idx   = hwdata[2:0];
  wire        bit_val   = hwdata[mcb_pkg::BITOP_VAL];
  wire [7:0]  bit_onehot = 8'h01 << bit_idx;
  wire        bit_on_ocv = (bit_idx == 3'(mcb_pkg::BIT_OCV));
  wire        bit_no_pre = ~mcb_pkg::PRELOAD_MASK[bit_idx];

  // control fields
  wire        master_output_enable       = ctrl_q[mcb_pkg::CTRL_MOE];
  wire        dac       = ctrl_q[mcb_pkg::CTRL_DAC];
  wire        sensor    = ctrl_q[mcb_pkg::CTRL_SR];
  wire        cur_mode  = ctrl_q[mcb_pkg::CTRL_CMS];
  wire        three_pwm = ctrl_q[mcb_pkg::CTRL_PCN];
  wire        current_limit_irq_enable      = ctrl_q[mcb_pkg::CTRL_CURRENT_LIMIT_IRQ_ENABLE];

  // active configuration fields; bit 3 taken directly from cfg_pre_q
  wire        edge_pol  = cfg_act_q[mcb_pkg::BIT_EDGE_POL];
  wire        hdm_en    = cfg_act_q[mcb_pkg::BIT_HW_DEMAG];
  wire        sdm_en    = cfg_act_q[mcb_pkg::BIT_SIM_DEMAG];
  wire        overcurrent_voltage_protect       = cfg_pre_q[mcb_pkg::BIT_OCV];
  wire        os2       = cfg_act_q[mcb_pkg::BIT_OS2];
  wire        os1       = cfg_act_q[mcb_pkg::BIT_OS1];
  wire        os0       = cfg_act_q[mcb_pkg::BIT_OS0];

  // preload transfer event
  wire        update    = dac ? wr_phase : comm_event;

  // zero crossing edge on the synchronised comparator
  wire        cmp_rise  = cmp_s2_q & ~cmp_s3_q;
  wire        cmp_fall  = ~cmp_s2_q & cmp_s3_q;
  wire        zc_det    = edge_pol ? cmp_rise : cmp_fall;

  // overcurrent handling
  wire        clf       = clf_s2_q;
  wire        current_limit_irq_enable_hit  = current_limit_irq_enable & clf;
  wire        ocv_mode  = ~cur_mode | ~three_pwm;
  wire        oc_trip   = current_limit_irq_enable_hit & overcurrent_voltage_protect & ocv_mode;
  wire        pwm_gate  = pwm_in & ~clf;

  // pwm side selection
  wire        sel_less  = (step_q == mcb_pkg::STEP_CD) ? os2 :
                          (step_q == mcb_pkg::STEP_DZ) ? os1 : os0;
  wire        sel_sens  = (step_q == mcb_pkg::STEP_ZC) ? os0 : os2;
  wire        sel_low   = dac ? os0 : (sensor ? sel_sens : sel_less);

  // pwm applied on the chosen channel group
  wire [5:0]  pwm_grp   = sel_low ? ~mcb_pkg::HIGH_CH_MASK : mcb_pkg::HIGH_CH_MASK;
  wire [5:0]  pattern   = dac ? phase_q : run_pattern;
  wire [5:0]  gated     = pattern & (~pwm_grp | {6{pwm_gate}});

  // interrupt events
  wire [3:0]  irq_set   = {zc_det, sdm_en & sim_demag_in, hdm_en & hw_demag_in, current_limit_irq_enable_hit};

  // read mux
  wire [31:0] rd_cfg    = {24'h000000, 1'b0, cfg_pre_q[6:0]};
  wire [31:0] rd_ctrl   = {26'h0000000, ctrl_q};
  wire [31:0] rd_phase  = {26'h0000000, phase_q};
  wire [31:0] rd_active = {22'h000000, step_q, 1'b0, cfg_act_q[6:0]};
  wire [31:0] rd_irq    = {28'h0000000, irq_st_q};
  wire [31:0] rd_irq_en = {28'h0000000, irq_en_q};

  always_comb begin
    case (ra)
      mcb_pkg::ADDR_CFG_B:  hrdata_d = rd_cfg;
      mcb_pkg::ADDR_CTRL:   hrdata_d = rd_ctrl;
      mcb_pkg::ADDR_PHASE:  hrdata_d = rd_phase;
      mcb_pkg::ADDR_ACTIVE: hrdata_d = rd_active;
      mcb_pkg::ADDR_IRQ_ST: hrdata_d = rd_irq;
      mcb_pkg::ADDR_IRQ_EN: hrdata_d = rd_irq_en;
      default:              hrdata_d = 32'h00000000;
    endcase
  end

  // preloaded and immediate configuration
  always_comb begin
    cfg_pre_d = cfg_pre_q;
    if (wr_cfg) begin
      cfg_pre_d = {1'b0, hwdata[6:0]};
    end else if (wr_bitop) begin
      if (bit_no_pre) begin
        cfg_pre_d = (cfg_pre_q & ~mcb_pkg::PRELOAD_MASK);
        if (bit_on_ocv) begin
          cfg_pre_d[mcb_pkg::BIT_OCV] = bit_val;
        end
      end else if (bit_val) begin
        cfg_pre_d = cfg_pre_q | (bit_onehot & mcb_pkg::PRELOAD_MASK);
      end else begin
        cfg_pre_d = cfg_pre_q & ~(bit_onehot & mcb_pkg::PRELOAD_MASK);
      end
    end
  end

  // all preloaded bits move together
  always_comb begin
    cfg_act_d = cfg_act_q;
    if (update) begin
      cfg_act_d = cfg_pre_q & mcb_pkg::PRELOAD_MASK;
    end
  end

  // control; overcurrent trip wins over a software write
  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_ctrl) begin
      ctrl_d = hwdata[5:0];
    end
    if (oc_trip) begin
      ctrl_d[mcb_pkg::CTRL_MOE] = 1'b0;
    end
  end

  assign phase_d  = wr_phase ? hwdata[5:0] : phase_q;
  assign irq_en_d = wr_en ? hwdata[3:0] : irq_en_q;

  // sticky status: a new event wins over a clear
  assign irq_st_d = (irq_st_q & ~(wr_clr ? hwdata[3:0] : 4'h0)) | irq_set;

  // step tracking between commutation, demag and zero crossing
  always_comb begin
    step_d = step_q;
    case (step_q)
      mcb_pkg::STEP_CD: begin
        if (demag_event & ~sensor) begin
          step_d = mcb_pkg::STEP_DZ;
        end else if (zc_det & sensor) begin
          step_d = mcb_pkg::STEP_ZC;
        end
      end
      mcb_pkg::STEP_DZ: begin
        if (zc_det) begin
          step_d = mcb_pkg::STEP_ZC;
        end
      end
      mcb_pkg::STEP_ZC: step_d = step_q;
      default:          step_d = mcb_pkg::STEP_CD;
    endcase
    if (comm_event) begin
      step_d = mcb_pkg::STEP_CD;
    end
  end

  // motor outputs
  assign out_d = master_output_enable ? gated : mcb_pkg::OUT_RESET_LEVEL;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hrdata_q  <= 32'h00000000;
    end else begin
      wr_pend_q <= wr_start;
      wr_addr_q <= ra;
      hrdata_q  <= rd_start ? hrdata_d : 32'h00000000;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_pre_q <= mcb_pkg::CFG_B_RESET;
      cfg_act_q <= mcb_pkg::CFG_B_RESET;
      ctrl_q    <= mcb_pkg::CTRL_RESET;
      phase_q   <= mcb_pkg::PHASE_RESET;
      irq_st_q  <= mcb_pkg::IRQ_RESET;
      irq_en_q  <= mcb_pkg::IRQ_RESET;
      step_q    <= mcb_pkg::STEP_CD;
    end else begin
      cfg_pre_q <= cfg_pre_d;
      cfg_act_q <= cfg_act_d;
      ctrl_q    <= ctrl_d;
      phase_q   <= phase_d;
      irq_st_q  <= irq_st_d;
      irq_en_q  <= irq_en_d;
      step_q    <= step_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmp_s1_q <= 1'b0;
      cmp_s2_q <= 1'b0;
      cmp_s3_q <= 1'b0;
      clf_s1_q <= 1'b0;
      clf_s2_q <= 1'b0;
    end else begin
      cmp_s1_q <= bemf_cmp_pin;
      cmp_s2_q <= cmp_s1_q;
      cmp_s3_q <= cmp_s2_q;
      clf_s1_q <= current_loop_pin;
      clf_s2_q <= clf_s1_q;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_q <= mcb_pkg::OUT_RESET_LEVEL;
      low_q <= 1'b0;
      zc_q  <= 1'b0;
      hdm_q <= 1'b0;
      sdm_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      out_q <= out_d;
      low_q <= sel_low;
      zc_q  <= zc_det;
      hdm_q <= hdm_en & hw_demag_in;
      sdm_q <= sdm_en & sim_demag_in;
      irq_q <= |(irq_st_d & irq_en_d);
    end
  end

  assign hrdata        = hrdata_q;
  assign hreadyout     = 1'b1;
  assign hresp         = 1'b0;
  assign motor_outputs = out_q;
  assign pwm_on_low    = low_q;
  assign zc_event      = zc_q;
  assign hw_demag_evt  = hdm_q;
  assign sim_demag_evt = sdm_q;
  assign irq           = irq_q;

endmodule
`default_nettype wire

// [sim/mcb_checker.sv]
// mcb_checker: port-level checks of mcb_top
// assumes one clock hclk and an async active-low reset hresetn
`timescale 1ns/1ps
`default_nettype none
module mcb_checker (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        comm_event,
  input wire logic        demag_event,
  input wire logic        hw_demag_in,
  input wire logic        sim_demag_in,
  input wire logic        pwm_in,
  input wire logic        bemf_cmp_pin,
  input wire logic        current_loop_pin,
  input wire logic [5:0]  motor_outputs,
  input wire logic        pwm_on_low,
  input wire logic        zc_event,
  input wire logic        hw_demag_evt,
  input wire logic        sim_demag_evt,
  input wire logic        irq
);
  logic       aw;
  logic [5:0] grp;
  logic [3:0] wsh_q;
  logic       rd_q;
  logic [5:0] bh_q;
  logic [5:0] ev_q;
  assign aw = hsel && hready && htrans == mcb_pkg::HTRANS_NONSEQ;
  assign grp = pwm_on_low ? ~mcb_pkg::HIGH_CH_MASK : mcb_pkg::HIGH_CH_MASK;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wsh_q <= 4'h0;
      rd_q <= 1'b0;
      bh_q <= 6'h00;
      ev_q <= 6'h00;
    end else begin
      wsh_q <= {wsh_q[2:0], aw && hwrite};
      rd_q <= aw && !hwrite && haddr[7:0] == mcb_pkg::ADDR_CFG_B;
      bh_q <= {bh_q[4:0], bemf_cmp_pin};
      ev_q <= {ev_q[4:0], comm_event | demag_event | zc_event | aw | (bemf_cmp_pin ^ bh_q[0])};
    end
  end
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  hw_demag_gate_a: assert property (hw_demag_evt |-> $past(hw_demag_in))
    else $error("hw demag event without input");
  sim_demag_gate_a: assert property (sim_demag_evt |-> $past(sim_demag_in))
    else $error("sim demag event without input");
  pwm_gap_quiet_a: assert property (!$past(pwm_in) |-> (motor_outputs & grp) == 6'h00)
    else $error("pwm group driven in pwm off time");
  loop_pwm_off_a: assert property (current_loop_pin [*4] |=> (motor_outputs & grp) == 6'h00)
    else $error("pwm group driven while current loop flag set");
  irq_release_a: assert property ($fell(irq) |-> wsh_q != 4'h0)
    else $error("irq dropped without a register write");
  cfg_top_zero_a: assert property (rd_q |-> hrdata[31:7] == 25'h0)
    else $error("config read shows bits above 6");
  zc_cause_a: assert property (zc_event |-> bh_q != 6'h00 && bh_q != 6'h3F)
    else $error("zero crossing without comparator change");
  side_change_a: assert property ($changed(pwm_on_low) |-> ev_q != 6'h00)
    else $error("pwm side changed without an update event");
endmodule
bind mcb_top mcb_checker i_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .comm_event(comm_event),
  .demag_event(demag_event), .hw_demag_in(hw_demag_in), .sim_demag_in(sim_demag_in),
  .pwm_in(pwm_in), .bemf_cmp_pin(bemf_cmp_pin), .current_loop_pin(current_loop_pin),
  .motor_outputs(motor_outputs), .pwm_on_low(pwm_on_low), .zc_event(zc_event),
  .hw_demag_evt(hw_demag_evt), .sim_demag_evt(sim_demag_evt), .irq(irq)
);
`default_nettype wire

// [sim/mcb_top_test.sv]
// mcb_top_test: self-checking bench for mcb_top
// assumes the bench is the only AHB-Lite master and the clock runs at 25 MHz
`timescale 1ns/1ps
`default_nettype none
module mcb_top_test;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        comm_event;
  logic        demag_event;
  logic        hw_demag_in;
  logic        sim_demag_in;
  logic        pwm_in;
  logic [5:0]  run_pattern;
  logic        bemf_cmp_pin;
  logic        current_loop_pin;
  logic [5:0]  motor_outputs;
  logic        pwm_on_low;
  logic        zc_event;
  logic        hw_demag_evt;
  logic        sim_demag_evt;
  logic        irq;
  logic [31:0] d;
  int          failures;
  int          total_checks;
  int          cyc;
  int          zc_n;
  mcb_top i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .comm_event(comm_event), .demag_event(demag_event),
    .hw_demag_in(hw_demag_in), .sim_demag_in(sim_demag_in), .pwm_in(pwm_in),
    .run_pattern(run_pattern), .bemf_cmp_pin(bemf_cmp_pin),
    .current_loop_pin(current_loop_pin), .motor_outputs(motor_outputs),
    .pwm_on_low(pwm_on_low), .zc_event(zc_event), .hw_demag_evt(hw_demag_evt),
    .sim_demag_evt(sim_demag_evt), .irq(irq)
  );
  always #20 hclk = ~hclk;
  always @(posedge hclk) begin
    if (zc_event === 1'b1) zc_n <= zc_n + 1;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      complete_run();
    end
  end
  task complete_run();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge hclk);
  endtask
  // address phase, then data phase, each held until hready
  task bus(input logic [7:0] a, input logic w, input logic [31:0] v);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= mcb_pkg::HTRANS_NONSEQ;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= v;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    d = hrdata;
    chk(hresp, 1'b0);
  endtask
  task pulse(input logic [3:0] m);
    {sim_demag_in, hw_demag_in, demag_event, comm_event} <= m;
    @(posedge hclk);
    {sim_demag_in, hw_demag_in, demag_event, comm_event} <= 4'h0;
    tick(1);
  endtask
  task t_regs();
    bus(mcb_pkg::ADDR_CFG_B, 0, 0); chk(d, 32'h0);
    bus(8'h40, 0, 0); chk(d, 32'h0);
    bus(mcb_pkg::ADDR_CFG_B, 1, 32'h7F);
    bus(mcb_pkg::ADDR_CFG_B, 0, 0); chk(d, 32'h7F);
  endtask
  task t_preload();
    bus(mcb_pkg::ADDR_CTRL, 1, 32'h01);
    bus(mcb_pkg::ADDR_CFG_B, 1, 32'h75);
    bus(mcb_pkg::ADDR_ACTIVE, 0, 0); chk(d[6:0], 7'h00);
    pulse(4'h1); tick(1);
    bus(mcb_pkg::ADDR_ACTIVE, 0, 0); chk(d[9:0], 10'h075);
    chk(pwm_on_low, 1'b1); chk(motor_outputs, 6'h15);
    pulse(4'h2); tick(1);
    chk(pwm_on_low, 1'b0); chk(motor_outputs, 6'h2A);
    bus(mcb_pkg::ADDR_CTRL, 1, 32'h05);
    pulse(4'h1); pulse(4'h2); tick(1);
    chk(pwm_on_low, 1'b1);
  endtask
  task t_direct();
    bus(mcb_pkg::ADDR_CTRL, 1, 32'h03);
    bus(mcb_pkg::ADDR_CFG_B, 1, 32'h06);
    bus(mcb_pkg::ADDR_PHASE, 1, 32'h3F); tick(2);
    chk(pwm_on_low, 1'b0); chk(motor_outputs, 6'h2A);
    bus(mcb_pkg::ADDR_CFG_B, 1, 32'h01); tick(2);
    chk(pwm_on_low, 1'b0);
    bus(mcb_pkg::ADDR_PHASE, 1, 32'h3F); tick(2);
    chk(pwm_on_low, 1'b1); chk(motor_outputs, 6'h15);
    pwm_in <= 1'b1; tick(2);
    chk(motor_outputs, 6'h3F);
    bus(mcb_pkg::ADDR_CTRL, 1, 32'h02); tick(2);
    chk(motor_outputs, mcb_pkg::OUT_RESET_LEVEL);
    pwm_in <= 1'b0;
  endtask
  task t_bitop();
    bus(mcb_pkg::ADDR_CFG_B, 1, 32'h77);
    bus(mcb_pkg::ADDR_BITOP, 1, 32'h103);
    bus(mcb_pkg::ADDR_CFG_B, 0, 0); chk(d, 32'h08);
    bus(mcb_pkg::ADDR_BITOP, 1, 32'h105);
    bus(mcb_pkg::ADDR_CFG_B, 0, 0); chk(d, 32'h28);
    bus(mcb_pkg::ADDR_BITOP, 1, 32'h007);
    bus(mcb_pkg::ADDR_CFG_B, 0, 0);
    chk(d, 32'h08);
  endtask
  // ctrl, config, expected output enable, expected irq
  localparam logic [17:0] OC [5] = '{{8'h21, 8'h08, 2'b01}, {8'h21, 8'h00, 2'b11},
    {8'h39, 8'h08, 2'b11}, {8'h31, 8'h08, 2'b01}, {8'h01, 8'h08, 2'b10}};
  task t_over();
    pwm_in <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      bus(mcb_pkg::ADDR_IRQ_EN, 1, 32'h1);
      bus(mcb_pkg::ADDR_CFG_B, 1, {24'h0, OC[i][9:2]});
      bus(mcb_pkg::ADDR_CTRL, 1, {24'h0, OC[i][17:10]});
      current_loop_pin <= 1'b1; tick(6);
      bus(mcb_pkg::ADDR_CTRL, 0, 0); chk(d[0], OC[i][1]);
      chk(irq, OC[i][0]);
      chk(motor_outputs, OC[i][1] ? 6'h2A : 6'h00);
      current_loop_pin <= 1'b0; tick(4);
      bus(mcb_pkg::ADDR_IRQ_CLR, 1, 32'h1); tick(3);
      chk(irq, 1'b0);
    end
    pwm_in <= 1'b0;
  endtask
  task t_demag();
    logic [7:0] c;
    bus(mcb_pkg::ADDR_CTRL, 1, 32'h01);
    bus(mcb_pkg::ADDR_IRQ_EN, 1, 32'h0);
    for (int i = 0; i < 3; i++) begin
      c = (i == 0) ? 8'h00 : (i == 1) ? 8'h20 : 8'h10;
      bus(mcb_pkg::ADDR_CFG_B, 1, {24'h0, c});
      pulse(4'h1);
      {sim_demag_in, hw_demag_in} <= 2'b11;
      @(posedge hclk);
      {sim_demag_in, hw_demag_in} <= 2'b00;
      @(posedge hclk);
      chk(hw_demag_evt, c[5]);
      chk(sim_demag_evt, c[4]);
    end
    bus(mcb_pkg::ADDR_IRQ_ST, 0, 0); chk(d[2:1], 2'h3);
    chk(irq, 1'b0);
    bus(mcb_pkg::ADDR_IRQ_EN, 1, 32'h6); tick(2);
    chk(irq, 1'b1);
    bus(mcb_pkg::ADDR_IRQ_CLR, 1, 32'h6); tick(3);
    chk(irq, 1'b0);
  endtask
  task t_zc();
    int n;
    for (int p = 0; p < 2; p++) begin
      bus(mcb_pkg::ADDR_CFG_B, 1, p ? 32'h40 : 32'h00);
      bemf_cmp_pin <= ~p[0];
      pulse(4'h1); pulse(4'h2); tick(6);
      n = zc_n;
      bemf_cmp_pin <= p[0]; tick(8);
      chk(zc_n - n, 1);
      bemf_cmp_pin <= ~p[0]; tick(8);
      chk(zc_n - n, 1);
    end
  endtask
  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    {hsel, hwrite, pwm_in, bemf_cmp_pin, current_loop_pin} = 5'h00;
    {sim_demag_in, hw_demag_in, demag_event, comm_event} = 4'h0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwdata = 32'h0;
    run_pattern = 6'h3F;
    {failures, total_checks, cyc, zc_n} = '0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_preload();
    t_direct();
    t_bitop();
    t_over();
    t_demag();
    t_zc();
    complete_run();
  end
endmodule
`default_nettype wire
